// *** hw/blc_pkg.sv ***
package blc_pkg;
  // Behaviour
  // (RULE1) bit 31 resets core, then self-clears
  // (RULE2) bit 30 resets timing generator, self-clears
  // (RULE3) bit 29 resets register block, self-clears
  // (RULE4) register reset keeps interrupt status; software acknowledges
  // (RULE5) bit 28 raises masked software interrupt
  // (RULE6) tx test abort stops after byte, closes crc
  // (RULE7) rx test abort: packet end or immediate rf off
  // (RULE8) bit 25 aborts advertising event, self-clears
  // (RULE9) bit 24 aborts scan window, self-clears
  // (RULE10) bit 22 forces single exchange, md passed through
  // (RULE11) bit 21 disables sequence number handling
  // (RULE12) bit 20 disables acknowledge scheme
  // (RULE13) bit 19 bypasses payload cipher, mic kept
  // (RULE14) bit 18 bypasses whitening
  // (RULE15) bit 17 keeps rx crc, zeros tx crc
  // (RULE16) bit 16 disables hop channel remapping
  // (RULE17) bit 9 filters advertising error reports
  // (RULE18) bit 8 enables exchange table prefetch
  // (RULE19) bits 7:4 default rx window, never zero; the code resets it to zero and accepts a written zero
  // (RULE20) bits 2:0 sync word error limit
  // (RULE21) undefined bits read zero, ignore writes

  localparam logic [31:0] CTRL_ADDR     = 32'h4000_0000;
  localparam logic [31:0] SWIRQ_ADDR    = 32'h4000_0300;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] CTRL_CMD_MASK = 32'hf700_0000;
  localparam logic [31:0] CTRL_CFG_MASK = 32'h007f_03f7;

  localparam int CORE_RST_BIT   = 31;
  localparam int TG_RST_BIT     = 30;
  localparam int REG_RST_BIT    = 29;
  localparam int SWIRQ_REQ_BIT  = 28;
  localparam int RF_ABORT_BIT   = 26;
  localparam int ADV_ABORT_BIT  = 25;
  localparam int SCAN_ABORT_BIT = 24;
  localparam int MD_DIS_BIT     = 22;
  localparam int SN_DIS_BIT     = 21;
  localparam int ACK_DIS_BIT    = 20;
  localparam int CIPHER_DIS_BIT = 19;
  localparam int WHIT_DIS_BIT   = 18;
  localparam int CRC_DIS_BIT    = 17;
  localparam int HOP_DIS_BIT    = 16;
  localparam int ADV_FILT_BIT   = 9;
  localparam int PREFETCH_BIT   = 8;
  localparam int RXWIN_LSB      = 4;
  localparam int SYNC_LSB       = 0;

  localparam int   SWIRQ_MASK_BIT   = 0;
  localparam int   SWIRQ_ACK_BIT    = 1;
  localparam logic SWIRQ_MASK_RESET = 1'b0;

  localparam logic [3:0]  RST_CYCLES   = 4'h8;
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          CYC_PER_US   = 1000000 / CLK_PERIOD_PS;
  localparam logic [23:0] TX_CRC_BLANK = 24'h00_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {RF_IDLE, RF_WAIT_BYTE, RF_WAIT_PKT} blc_rf_st_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } blc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } blc_axi_rsp_t;

  typedef struct packed {
    logic        inf_tx;
    logic        inf_rx;
    logic        byte_end;
    logic        pkt_end;
    logic        aa_detected;
    logic        adv_done;
    logic        scan_done;
    logic        control_struct_cipher_enable;
    logic        rpt_valid;
    logic        rpt_error;
    logic        rpt_adv_chan;
    logic [23:0] tx_crc;
  } blc_ll_in_t;

  typedef struct packed {
    logic        core_reset;
    logic        tg_reset;
    logic        rf_tx_stop;
    logic        rf_crc_finish;
    logic        rf_rx_stop;
    logic        rf_off;
    logic        advertising_abort;
    logic        scan_abort;
    logic        more_data_disable;
    logic        seqnum_disable;
    logic        ack_scheme_disable;
    logic        mic_enable;
    logic        payload_encrypt;
    logic        whitening_disable;
    logic        checksum_strip_disable;
    logic        hop_remapping_disable;
    logic        adv_error_filter_enable;
    logic        exchange_prefetch_enable;
    logic [3:0]  default_rx_window;
    logic [11:0] rx_window_cycles;
    logic [2:0]  sync_word_error_limit;
    logic        rpt_to_sw;
    logic [23:0] tx_crc;
  } blc_ll_out_t;

  typedef struct packed {
    logic         aw_got;
    logic         w_got;
    logic [31:0]  awaddr;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    blc_axi_rsp_t rsp;
    logic [31:0]  ctrl;
    logic         irq_mask;
    logic         irq_pend;
    logic         irq_out;
    logic [3:0]   core_cnt;
    logic [3:0]   tg_cnt;
    blc_rf_st_t   rf_st;
    blc_ll_out_t  lo;
  } blc_state_t;
endpackage

// *** hw/blc_core_control.sv ***
`timescale 1ns/100ps
module blc_core_control (
  input  logic                 aclk,
  input  logic                 aresetn,
  input  blc_pkg::blc_axi_req_t s_axi_req,
  output blc_pkg::blc_axi_rsp_t s_axi_rsp,
  input  blc_pkg::blc_ll_in_t  ll_in,
  output blc_pkg::blc_ll_out_t ll_out,
  output logic                 software_irq_out
);
  import blc_pkg::*;

  blc_state_t state_q;
  blc_state_t state_d;

  assign s_axi_rsp        = state_q.rsp;
  assign ll_out           = state_q.lo;
  assign software_irq_out = state_q.irq_out;

  always_comb
  begin
    logic [31:0] wmask;
    logic        do_wr;
    logic        rf_done;
    logic        sw_set;
    logic        ack;
    wmask   = '0;
    do_wr   = 1'b0;
    rf_done = 1'b0;
    sw_set  = 1'b0;
    ack     = 1'b0;
    state_d = state_q;

    // pulses last one cycle
    state_d.lo.rf_tx_stop    = 1'b0;
    state_d.lo.rf_crc_finish = 1'b0;
    state_d.lo.rf_rx_stop    = 1'b0;
    state_d.lo.rf_off        = 1'b0;

    // core soft reset: bit reads one until the last cycle of the pulse train
    state_d.lo.core_reset = 1'b0;
    if (state_q.ctrl[CORE_RST_BIT])
    begin
      state_d.lo.core_reset = 1'b1; // RULE1
      if (state_q.core_cnt == 4'(RST_CYCLES - 4'h1))
      begin
        state_d.core_cnt = 4'h0;
        state_d.ctrl[CORE_RST_BIT] = 1'b0; // RULE1
      end
      else
      begin
        state_d.core_cnt = 4'(state_q.core_cnt + 4'h1);
      end
    end

    state_d.lo.tg_reset = 1'b0;
    if (state_q.ctrl[TG_RST_BIT])
    begin
      state_d.lo.tg_reset = 1'b1; // RULE2
      if (state_q.tg_cnt == 4'(RST_CYCLES - 4'h1))
      begin
        state_d.tg_cnt = 4'h0;
        state_d.ctrl[TG_RST_BIT] = 1'b0; // RULE2
      end
      else
      begin
        state_d.tg_cnt = 4'(state_q.tg_cnt + 4'h1);
      end
    end

    // register block reset: config and mask to reset values, commands in
    // flight and the pending software interrupt are left alone
    if (state_q.ctrl[REG_RST_BIT])
    begin
      state_d.ctrl = (state_d.ctrl & CTRL_CMD_MASK) | (CTRL_RESET & CTRL_CFG_MASK); // RULE3
      state_d.ctrl[REG_RST_BIT] = 1'b0; // RULE3
      state_d.irq_mask = SWIRQ_MASK_RESET; // RULE4
    end

    if (state_q.ctrl[SWIRQ_REQ_BIT])
    begin
      sw_set = state_q.irq_mask; // RULE5
      state_d.ctrl[SWIRQ_REQ_BIT] = 1'b0; // RULE5
    end

    // rf test abort tracking
    unique case (state_q.rf_st)
      RF_IDLE:
      begin
        if (state_q.ctrl[RF_ABORT_BIT])
        begin
          if (ll_in.inf_tx)
          begin
            state_d.rf_st = RF_WAIT_BYTE; // RULE6
          end
          else if (ll_in.inf_rx && ll_in.aa_detected)
          begin
            state_d.rf_st = RF_WAIT_PKT; // RULE7
          end
          else
          begin
            // no packet under way: cut the radio at once if it is receiving
            state_d.lo.rf_off = ll_in.inf_rx; // RULE7
            rf_done = 1'b1;
          end
        end
      end
      RF_WAIT_BYTE:
      begin
        if (ll_in.byte_end || !ll_in.inf_tx)
        begin
          state_d.lo.rf_tx_stop    = 1'b1; // RULE6
          state_d.lo.rf_crc_finish = 1'b1; // RULE6
          state_d.rf_st = RF_IDLE;
          rf_done = 1'b1;
        end
      end
      RF_WAIT_PKT:
      begin
        if (ll_in.pkt_end || !ll_in.inf_rx)
        begin
          state_d.lo.rf_rx_stop = 1'b1; // RULE7
          state_d.rf_st = RF_IDLE;
          rf_done = 1'b1;
        end
      end
    endcase
    if (rf_done)
    begin
      state_d.ctrl[RF_ABORT_BIT] = 1'b0;
    end

    // abort requests stay up until the sequencer reports completion
    if (state_q.ctrl[ADV_ABORT_BIT] && ll_in.adv_done)
    begin
      state_d.ctrl[ADV_ABORT_BIT] = 1'b0; // RULE8
    end
    if (state_q.ctrl[SCAN_ABORT_BIT] && ll_in.scan_done)
    begin
      state_d.ctrl[SCAN_ABORT_BIT] = 1'b0; // RULE9
    end

    // axi4-lite read channel, one read in flight
    if (state_q.rsp.rvalid && s_axi_req.rready)
    begin
      state_d.rsp.rvalid = 1'b0;
    end
    if (state_q.rsp.arready && s_axi_req.arvalid)
    begin
      state_d.rsp.rvalid = 1'b1;
      state_d.rsp.rresp  = RESP_OKAY;
      if (s_axi_req.araddr == CTRL_ADDR)
      begin
        state_d.rsp.rdata = state_q.ctrl & (CTRL_CMD_MASK | CTRL_CFG_MASK); // RULE21
      end
      else if (s_axi_req.araddr == SWIRQ_ADDR)
      begin
        state_d.rsp.rdata = '0;
        state_d.rsp.rdata[SWIRQ_MASK_BIT] = state_q.irq_mask;
        state_d.rsp.rdata[SWIRQ_ACK_BIT]  = state_q.irq_pend;
      end
      else
      begin
        state_d.rsp.rdata = '0;
        state_d.rsp.rresp = RESP_SLVERR;
      end
    end
    state_d.rsp.arready = !state_d.rsp.rvalid;

    // axi4-lite write channels, address and data in either order
    if (state_q.rsp.bvalid && s_axi_req.bready)
    begin
      state_d.rsp.bvalid = 1'b0;
    end
    if (state_q.rsp.awready && s_axi_req.awvalid)
    begin
      state_d.aw_got = 1'b1;
      state_d.awaddr = s_axi_req.awaddr;
    end
    if (state_q.rsp.wready && s_axi_req.wvalid)
    begin
      state_d.w_got = 1'b1;
      state_d.wdata = s_axi_req.wdata;
      state_d.wstrb = s_axi_req.wstrb;
    end
    do_wr = state_d.aw_got && state_d.w_got && !state_d.rsp.bvalid;
    for (int i = 0; i < 4; i++)
    begin
      wmask[8*i +: 8] = {8{state_d.wstrb[i]}};
    end

    if (do_wr)
    begin
      state_d.aw_got     = 1'b0;
      state_d.w_got      = 1'b0;
      state_d.rsp.bvalid = 1'b1;
      state_d.rsp.bresp  = RESP_OKAY;
      if (state_d.awaddr == CTRL_ADDR)
      begin
        // config bits take the written value; command bits only set,
        // so a write of zero never cancels an action under way
        state_d.ctrl = (state_d.ctrl & ~(CTRL_CFG_MASK & wmask))
                     | (state_d.wdata & CTRL_CFG_MASK & wmask)
                     | (state_d.wdata & CTRL_CMD_MASK & wmask); // RULE21
      end
      else if (state_d.awaddr == SWIRQ_ADDR)
      begin
        if (state_d.wstrb[0])
        begin
          state_d.irq_mask = state_d.wdata[SWIRQ_MASK_BIT];
          ack = state_d.wdata[SWIRQ_ACK_BIT];
        end
      end
      else
      begin
        state_d.rsp.bresp = RESP_SLVERR;
      end
    end
    state_d.rsp.awready = !state_d.aw_got && !state_d.rsp.bvalid;
    state_d.rsp.wready  = !state_d.w_got && !state_d.rsp.bvalid;

    // a request in the cycle of the acknowledge wins
    state_d.irq_pend = (state_q.irq_pend && !ack) || sw_set; // RULE4
    state_d.irq_out  = state_d.irq_pend && state_d.irq_mask; // RULE5

    // static controls follow the register
    state_d.lo.advertising_abort = state_d.ctrl[ADV_ABORT_BIT]; // RULE8
    state_d.lo.scan_abort        = state_d.ctrl[SCAN_ABORT_BIT]; // RULE9
    state_d.lo.more_data_disable = state_d.ctrl[MD_DIS_BIT]; // RULE10
    state_d.lo.seqnum_disable    = state_d.ctrl[SN_DIS_BIT]; // RULE11
    state_d.lo.ack_scheme_disable = state_d.ctrl[ACK_DIS_BIT]; // RULE12
    // mic follows the descriptor flag alone; only the payload is bypassed
    state_d.lo.mic_enable = ll_in.control_struct_cipher_enable; // RULE13
    state_d.lo.payload_encrypt = ll_in.control_struct_cipher_enable
                               && !state_d.ctrl[CIPHER_DIS_BIT]; // RULE13
    state_d.lo.whitening_disable = state_d.ctrl[WHIT_DIS_BIT]; // RULE14
    state_d.lo.checksum_strip_disable = state_d.ctrl[CRC_DIS_BIT]; // RULE15
    state_d.lo.tx_crc = state_d.ctrl[CRC_DIS_BIT] ? TX_CRC_BLANK : ll_in.tx_crc; // RULE15
    state_d.lo.hop_remapping_disable = state_d.ctrl[HOP_DIS_BIT]; // RULE16
    state_d.lo.adv_error_filter_enable = state_d.ctrl[ADV_FILT_BIT]; // RULE17
    state_d.lo.rpt_to_sw = ll_in.rpt_valid && (!ll_in.rpt_error
                         || !ll_in.rpt_adv_chan
                         || !state_d.ctrl[ADV_FILT_BIT]); // RULE17
    state_d.lo.exchange_prefetch_enable = state_d.ctrl[PREFETCH_BIT]; // RULE18
    state_d.lo.default_rx_window = state_d.ctrl[RXWIN_LSB +: 4]; // RULE19
    // window in clock cycles; a zero field gives zero, software must avoid it
    state_d.lo.rx_window_cycles = 12'(state_d.ctrl[RXWIN_LSB +: 4] * CYC_PER_US); // RULE19
    state_d.lo.sync_word_error_limit = state_d.ctrl[SYNC_LSB +: 3]; // RULE20
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end
endmodule

// *** testbench/blc_core_control_sva.sv ***
`timescale 1ns/100ps
module blc_core_control_sva (
  input logic                  aclk,
  input logic                  aresetn,
  input blc_pkg::blc_axi_req_t s_axi_req,
  input blc_pkg::blc_axi_rsp_t s_axi_rsp,
  input blc_pkg::blc_ll_in_t   ll_in,
  input blc_pkg::blc_ll_out_t  ll_out,
  input logic                  software_irq_out
);
  import blc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_core_pulse: assert property (
    $rose(ll_out.core_reset) |-> ll_out.core_reset [*8] ##1 !ll_out.core_reset)
    else $error("core reset pulse length wrong");
  a_tg_pulse: assert property (
    $rose(ll_out.tg_reset) |-> ll_out.tg_reset [*8] ##1 !ll_out.tg_reset)
    else $error("timing reset pulse length wrong");
  a_crc_blank: assert property (
    ll_out.checksum_strip_disable |-> ll_out.tx_crc == TX_CRC_BLANK)
    else $error("tx crc not blanked");
  a_adv_filter: assert property (
    $past(ll_in.rpt_valid & ll_in.rpt_error & ll_in.rpt_adv_chan)
    && ll_out.adv_error_filter_enable |-> !ll_out.rpt_to_sw)
    else $error("errored report passed filter");
  a_mic_follow: assert property (
    $past(aresetn) |-> ll_out.mic_enable == $past(ll_in.control_struct_cipher_enable))
    else $error("mic enable not following flag");
  a_rf_off_cause: assert property (
    $rose(ll_out.rf_off) |-> $past(ll_in.inf_rx & !ll_in.aa_detected))
    else $error("rf off without cause");
  a_adv_release: assert property (
    $fell(ll_out.advertising_abort) |-> $past(ll_in.adv_done))
    else $error("advertising abort dropped early");
  a_scan_release: assert property (
    $fell(ll_out.scan_abort) |-> $past(ll_in.scan_done))
    else $error("scan abort dropped early");
  a_window_scale: assert property (
    ll_out.rx_window_cycles == 12'(ll_out.default_rx_window) * 12'd250)
    else $error("rx window cycles wrong");
  c_core: cover property ($rose(ll_out.core_reset));
  c_irq: cover property ($rose(software_irq_out));
  c_tx_stop: cover property (ll_out.rf_tx_stop);
endmodule

bind blc_core_control blc_core_control_sva u_sva (
  .aclk             (aclk),
  .aresetn          (aresetn),
  .s_axi_req        (s_axi_req),
  .s_axi_rsp        (s_axi_rsp),
  .ll_in            (ll_in),
  .ll_out           (ll_out),
  .software_irq_out (software_irq_out)
);

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import blc_pkg::*;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  blc_axi_req_t req = '0;
  blc_axi_rsp_t rsp;
  blc_ll_in_t   li = '0;
  blc_ll_out_t  lo;
  logic         irq;
  int           errors = 0;
  int           checked = 0;
  logic [31:0]  pat [2] = '{32'h007f_f3ff, 32'h0015_02a5};
  logic [14:0]  cfg [2] = '{15'h7fff, 15'h1b55};

  always #2 aclk = ~aclk;

  blc_core_control DUT (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .s_axi_req        (req),
    .s_axi_rsp        (rsp),
    .ll_in            (li),
    .ll_out           (lo),
    .software_irq_out (irq)
  );

  task automatic wrap_up;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // a hung handshake ends the run as a mismatch
  task automatic lost;
    errors++;
    wrap_up;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
      begin
        req.bready <= 1'b0;
        chk(32'(rsp.bresp), 32'(e));
        return;
      end
    end
    lost;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
      begin
        req.rready <= 1'b0;
        chk(rsp.rdata, d);
        chk(32'(rsp.rresp), 32'(e));
        return;
      end
    end
    lost;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return lo.rf_tx_stop;
      1: return lo.rf_rx_stop;
      2: return lo.rf_off;
      3: return lo.advertising_abort;
      4: return lo.scan_abort;
      5: return lo.core_reset;
      default: return lo.tg_reset;
    endcase
  endfunction

  task automatic wt(input int k, input logic v);
    for (int n = 0; n < 60; n++)
    begin
      @(posedge aclk);
      if (sig(k) === v)
        return;
    end
    lost;
  endtask

  initial
  begin
    int n;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_ADDR, CTRL_RESET, RESP_OKAY);
    rd(SWIRQ_ADDR, 32'h0, RESP_OKAY);
    wr(32'h4000_0004, 32'hffff_ffff, RESP_SLVERR);
    rd(32'h4000_0004, 32'h0, RESP_SLVERR);
    li.tx_crc <= 24'habcdef;
    li.control_struct_cipher_enable <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr(CTRL_ADDR, pat[i], RESP_OKAY);
      rd(CTRL_ADDR, pat[i] & CTRL_CFG_MASK, RESP_OKAY);
      cyc(2);
      chk(32'(lo.more_data_disable), 32'(cfg[i][14]));
      chk(32'(lo.seqnum_disable), 32'(cfg[i][13]));
      chk(32'(lo.ack_scheme_disable), 32'(cfg[i][12]));
      chk(32'(lo.whitening_disable), 32'(cfg[i][11]));
      chk(32'(lo.checksum_strip_disable), 32'(cfg[i][10]));
      chk(32'(lo.hop_remapping_disable), 32'(cfg[i][9]));
      chk(32'(lo.adv_error_filter_enable), 32'(cfg[i][8]));
      chk(32'(lo.exchange_prefetch_enable), 32'(cfg[i][7]));
      chk(32'(lo.default_rx_window), 32'(cfg[i][6:3]));
      chk(32'(lo.sync_word_error_limit), 32'(cfg[i][2:0]));
      chk(32'(lo.tx_crc), (i == 1) ? 32'h00ab_cdef : 32'h0);
      chk(32'(lo.payload_encrypt), 32'(i));
      li.rpt_valid    <= 1'b1;
      li.rpt_error    <= 1'b1;
      // errored advertising report is filtered, errored data report is not
      li.rpt_adv_chan <= (i == 0);
      @(posedge aclk);
      li.rpt_valid    <= 1'b0;
      @(posedge aclk);
      chk(32'(lo.rpt_to_sw), 32'(i));
    end
    for (int i = 0; i < 2; i++)
    begin
      n = 0;
      fork
        wr(CTRL_ADDR, pat[1] | (32'h8000_0000 >> i), RESP_OKAY);
        repeat (20)
        begin
          @(posedge aclk);
          if (sig(5 + i) === 1'b1)
            n++;
        end
      join
      chk(32'(n), 32'(RST_CYCLES));
      rd(CTRL_ADDR, pat[1], RESP_OKAY);
    end
    // command writes keep a legal receive window in the config field
    wr(SWIRQ_ADDR, 32'h1, RESP_OKAY);
    wr(CTRL_ADDR, pat[1] | 32'h1000_0000, RESP_OKAY);
    cyc(3);
    chk(32'(irq), 32'h1);
    rd(SWIRQ_ADDR, 32'h3, RESP_OKAY);
    wr(CTRL_ADDR, pat[1] | 32'h2000_0000, RESP_OKAY);
    rd(CTRL_ADDR, 32'h0, RESP_OKAY);
    rd(SWIRQ_ADDR, 32'h2, RESP_OKAY);
    wr(SWIRQ_ADDR, 32'h2, RESP_OKAY);
    rd(SWIRQ_ADDR, 32'h0, RESP_OKAY);
    wr(CTRL_ADDR, pat[1] | 32'h1000_0000, RESP_OKAY);
    cyc(3);
    chk(32'(irq), 32'h0);
    rd(SWIRQ_ADDR, 32'h0, RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      li.inf_tx      <= (i == 0);
      li.inf_rx      <= (i != 0);
      li.aa_detected <= (i == 1);
      wr(CTRL_ADDR, pat[1] | 32'h0400_0000, RESP_OKAY);
      fork
        begin
          wt(i, 1'b1);
          chk(32'(lo.rf_crc_finish), 32'(i == 0));
        end
        begin
          cyc(3);
          li.byte_end <= (i == 0);
          li.pkt_end  <= (i == 1);
          @(posedge aclk);
          li.byte_end <= 1'b0;
          li.pkt_end  <= 1'b0;
        end
      join
      li.inf_tx <= 1'b0;
      li.inf_rx <= 1'b0;
      rd(CTRL_ADDR, pat[1], RESP_OKAY);
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(CTRL_ADDR, pat[1] | (32'h0200_0000 >> i), RESP_OKAY);
      cyc(4);
      chk(32'(sig(3 + i)), 32'h1);
      li.adv_done  <= (i == 0);
      li.scan_done <= (i == 1);
      wt(3 + i, 1'b0);
      cyc(2);
      li.adv_done  <= 1'b0;
      li.scan_done <= 1'b0;
      rd(CTRL_ADDR, pat[1], RESP_OKAY);
    end
    // reset in mid-run brings the register back to its reset value
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    rd(CTRL_ADDR, CTRL_RESET, RESP_OKAY);
    rd(SWIRQ_ADDR, 32'h0, RESP_OKAY);
    wrap_up;
  end
endmodule
